// *** rtl/stg_pkg.sv ***
// constants, register map and field layout of the sensor timing generator
package stg_pkg;
  localparam int ADDR_W = 12;
  localparam int CNT_W = 20;
  localparam int TAPS = 48;
  localparam int TAPS_X2 = 24;
  localparam int TAPS_X4 = 12;
  localparam int EDGE_W = 6;
  localparam int NUM_GATES = 6;
  localparam int NUM_FAST = 6;
  localparam int TOG_TOTAL = 120;
  localparam int TOG_IDX_W = 7;
  // toggle slots per gate: start, shift 1..4, clear
  localparam int GATE_BASE [NUM_GATES] = '{0, 8, 24, 40, 56, 72};
  localparam int GATE_COUNT [NUM_GATES] = '{8, 16, 16, 16, 16, 48};
  localparam logic [1:0] SYNC_RUN_MIN = 2'h3;
  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_LINE_LEN = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_CLAMP_START = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_CLAMP_END = 12'h00C;
  localparam logic [ADDR_W-1:0] OFS_GATE_CFG = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h014;
  localparam logic [ADDR_W-1:0] OFS_FAST_BASE = 12'h020;
  localparam logic [ADDR_W-1:0] OFS_TOG_BASE = 12'h100;
  // control register fields
  localparam int CTRL_OUT_EN = 0;
  localparam int CTRL_SRC_SEL = 1;
  localparam int CTRL_POL = 2;
  localparam int CTRL_OSEL_LO = 3;
  localparam int CTRL_HOLD = 5;
  localparam int CTRL_CLAMP_EN = 6;
  localparam int CTRL_PIN_SEL = 7;
  localparam int CTRL_GPIO_VAL = 8;
  localparam int CTRL_SOFT_RST = 9;
  localparam int CTRL_W = 9;
  // gate config fields: initial polarity [5:0], toggle enable [13:8]
  localparam int GCFG_EN_LO = 8;
  // status fields: pixel counter [19:0], full-reset flag, sync active state after polarity
  localparam int STAT_FULL_RST = 20;
  localparam int STAT_SYNC_ACT = 21;
  // fast clock config fields
  localparam int FC_R1_LO = 0;
  localparam int FC_F1_LO = 6;
  localparam int FC_R2_LO = 12;
  localparam int FC_F2_LO = 18;
  localparam int FC_RATE_LO = 24;
  localparam int FC_W = 26;
  localparam logic [1:0] RATE_X1 = 2'h0;
  localparam logic [1:0] RATE_X2 = 2'h1;
  localparam logic [1:0] RATE_X4 = 2'h2;
  localparam logic [1:0] OSEL_LINE = 2'h0;
  localparam logic [1:0] OSEL_CLAMP = 2'h1;
  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;
  localparam logic [CNT_W-1:0] LINE_LEN_RST = 20'h00FFF;
  localparam logic [CNT_W-1:0] CLAMP_START_RST = 20'h00000;
  localparam logic [CNT_W-1:0] CLAMP_END_RST = 20'h00000;
  localparam logic [13:0] GATE_CFG_RST = 14'h0000;
  localparam logic [FC_W-1:0] FAST_RST = 26'h0000600;
endpackage

// *** rtl/stg_timing_gen.sv ***
// sensor timing generator: line sync, slow gates, fast tap waveforms, APB registers
`timescale 1ns/10ps
`default_nettype none
module stg_timing_gen
  import stg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // line sync pin, two-way
  input wire logic ext_line_sync_input,
  output logic line_sync_out,
  output logic line_sync_oe,
  // slow gates
  output logic [NUM_GATES-1:0] slow_gate,
  output logic shared_general_pin_three,
  output logic dummy_clamp_window,
  // fast clocks as 48-tap patterns per clock period, bit n = level in tap slot n
  output logic [TAPS-1:0] phase_clock_one,
  output logic [TAPS-1:0] phase_clock_one_inverse,
  output logic [TAPS-1:0] phase_clock_three,
  output logic [TAPS-1:0] phase_clock_three_inverse,
  output logic [TAPS-1:0] last_stage_clock_one,
  output logic [TAPS-1:0] last_stage_clock_two,
  output logic [TAPS-1:0] reset_gate_clock,
  output logic [TAPS-1:0] clamp_gate_clock
);

  // ==========================================================
  // register storage
  logic [CTRL_W-1:0] ctrl_q;
  logic [CNT_W-1:0] line_length_setting_q;
  logic [CNT_W-1:0] clamp_start_q;
  logic [CNT_W-1:0] clamp_end_q;
  logic [13:0] gate_cfg_q;
  logic [FC_W-1:0] fast_cfg_q [NUM_FAST];
  logic [CNT_W-1:0] toggle_position_q [TOG_TOTAL];
  logic full_rst_flag_q;
  logic soft_rst_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // line state
  logic [CNT_W-1:0] pixel_counter_q;
  logic [CNT_W-1:0] pixel_counter_d;
  logic [CNT_W-1:0] elapsed_q;
  logic [CNT_W-1:0] elapsed_d;
  logic line_cycle_pulse_q;
  logic line_cycle_pulse_d;
  logic mask_q;
  logic mask_d;
  logic [1:0] run_q;
  logic sync_s1_q;
  logic sync_s2_q;
  logic sync_s3_q;
  logic sync_lvl_q;
  logic win_d;
  logic win_q;
  logic sync_out_q;
  logic sync_oe_q;
  logic pin_q;
  logic [NUM_GATES-1:0] gate_q;
  logic [NUM_GATES-1:0] gate_d;
  logic [TAPS-1:0] wave_q [8];

  // control fields
  logic out_en;
  logic internal_mode;
  logic sync_active;
  assign out_en = ctrl_q[CTRL_OUT_EN];
  assign internal_mode = ctrl_q[CTRL_SRC_SEL];
  assign sync_active = sync_lvl_q ^ ctrl_q[CTRL_POL];

  // ==========================================================
  // apb access
  logic acc;
  logic wr;
  logic hit;
  logic [31:0] rd_d;
  logic [ADDR_W-1:0] tog_ofs;
  logic [TOG_IDX_W-1:0] tog_idx;
  logic tog_hit;
  logic [ADDR_W-1:0] fast_ofs;
  logic [2:0] fast_idx;
  logic fast_hit;

  assign acc = psel && penable && !pready_q;
  assign wr = psel && penable && pready_q && pwrite;
  assign tog_ofs = paddr - OFS_TOG_BASE;
  assign tog_idx = tog_ofs[TOG_IDX_W+1:2];
  assign tog_hit = (paddr >= OFS_TOG_BASE) && (tog_ofs[ADDR_W-1:TOG_IDX_W+2] == '0) &&
                   (int'(tog_idx) < TOG_TOTAL) && (paddr[1:0] == 2'h0);
  assign fast_ofs = paddr - OFS_FAST_BASE;
  assign fast_idx = fast_ofs[4:2];
  assign fast_hit = (paddr >= OFS_FAST_BASE) && (fast_ofs[ADDR_W-1:5] == '0) &&
                    (int'(fast_idx) < NUM_FAST) && (paddr[1:0] == 2'h0);

  // read mux; unmapped addresses read zero and flag an error
  always_comb
  begin
    rd_d = '0;
    hit = 1'b1;
    if (tog_hit)
      rd_d[CNT_W-1:0] = toggle_position_q[tog_idx];
    else if (fast_hit)
      rd_d[FC_W-1:0] = fast_cfg_q[fast_idx];
    else
    begin
      unique case (paddr)
        OFS_CTRL: rd_d[CTRL_W-1:0] = ctrl_q;
        OFS_LINE_LEN: rd_d[CNT_W-1:0] = line_length_setting_q;
        OFS_CLAMP_START: rd_d[CNT_W-1:0] = clamp_start_q;
        OFS_CLAMP_END: rd_d[CNT_W-1:0] = clamp_end_q;
        OFS_GATE_CFG: rd_d[13:0] = gate_cfg_q;
        OFS_STATUS:
        begin
          rd_d[CNT_W-1:0] = pixel_counter_q;
          rd_d[STAT_FULL_RST] = full_rst_flag_q;
          rd_d[STAT_SYNC_ACT] = sync_active;
        end
        default: hit = 1'b0;
      endcase
    end
  end

  // one wait state: answer comes in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
    else
    begin
      pready_q <= acc;
      pslverr_q <= acc && !hit;
      prdata_q <= (acc && !pwrite) ? rd_d : '0;
    end
  end

  // control and line registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      line_length_setting_q <= LINE_LEN_RST;
      clamp_start_q <= CLAMP_START_RST;
      clamp_end_q <= CLAMP_END_RST;
      gate_cfg_q <= GATE_CFG_RST;
      soft_rst_q <= 1'b0;
    end
    else
    begin
      soft_rst_q <= wr && (paddr == OFS_CTRL) && pwdata[CTRL_SOFT_RST];
      if (wr)
      begin
        unique case (paddr)
          OFS_CTRL: ctrl_q <= pwdata[CTRL_W-1:0];
          OFS_LINE_LEN: line_length_setting_q <= pwdata[CNT_W-1:0];
          OFS_CLAMP_START: clamp_start_q <= pwdata[CNT_W-1:0];
          OFS_CLAMP_END: clamp_end_q <= pwdata[CNT_W-1:0];
          OFS_GATE_CFG: gate_cfg_q <= pwdata[13:0];
          default: ;
        endcase
      end
    end
  end

  // full-reset flag is set by software reset and stays until power-on reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      full_rst_flag_q <= 1'b0;
    else if (soft_rst_q)
      full_rst_flag_q <= 1'b1;
  end

  // toggle position memory, no reset needed beyond zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < TOG_TOTAL; i++)
        toggle_position_q[i] <= '0;
    end
    else if (wr && tog_hit)
      toggle_position_q[tog_idx] <= pwdata[CNT_W-1:0];
  end

  // fast clock edge settings
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_FAST; i++)
        fast_cfg_q[i] <= FAST_RST;
    end
    else if (wr && fast_hit)
      fast_cfg_q[fast_idx] <= pwdata[FC_W-1:0];
  end

  // ==========================================================
  // line sync input: three flops, level accepted when the last two agree
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
      sync_lvl_q <= 1'b0;
    end
    else
    begin
      sync_s1_q <= ext_line_sync_input;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
      if (sync_s2_q == sync_s3_q)
        sync_lvl_q <= sync_s3_q;
    end
  end

  // ==========================================================
  // line-cycle pulse generation
  always_comb
  begin
    pixel_counter_d = pixel_counter_q;
    line_cycle_pulse_d = 1'b0;
    mask_d = mask_q;
    if (ctrl_q[CTRL_HOLD] && full_rst_flag_q)
    begin
      pixel_counter_d = '0;
    end
    else if (internal_mode)
    begin
      mask_d = 1'b0;
      if (pixel_counter_q == line_length_setting_q)
      begin
        pixel_counter_d = '0;
        line_cycle_pulse_d = 1'b1;
      end
      else
        pixel_counter_d = pixel_counter_q + 1'b1;
    end
    else
    begin
      // third active cycle makes the pulse
      if (sync_active && run_q == (SYNC_RUN_MIN - 2'h1) && !mask_q)
      begin
        line_cycle_pulse_d = 1'b1;
        mask_d = 1'b1;
        pixel_counter_d = '0;
      end
      else if (mask_q)
      begin
        if (pixel_counter_q >= line_length_setting_q)
          mask_d = 1'b0;
        else
          pixel_counter_d = pixel_counter_q + 1'b1;
      end
    end
  end

  // elapsed clocks since the pulse fell; saturates so a stalled line stays quiet
  always_comb
  begin
    if (line_cycle_pulse_q)
      elapsed_d = '0;
    else if (elapsed_q != '1)
      elapsed_d = elapsed_q + 1'b1;
    else
      elapsed_d = elapsed_q;
  end

  // pulse lasts one clock since the register drops it whenever the previous pulse was high
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pixel_counter_q <= '0;
      line_cycle_pulse_q <= 1'b0;
      mask_q <= 1'b0;
      run_q <= '0;
      elapsed_q <= '0;
    end
    else if (soft_rst_q)
    begin
      pixel_counter_q <= '0;
      line_cycle_pulse_q <= 1'b0;
      mask_q <= 1'b0;
      run_q <= '0;
      elapsed_q <= '0;
    end
    else
    begin
      pixel_counter_q <= pixel_counter_d;
      line_cycle_pulse_q <= line_cycle_pulse_d && !line_cycle_pulse_q;
      mask_q <= mask_d;
      run_q <= !sync_active ? 2'h0 : (run_q == SYNC_RUN_MIN) ? run_q : run_q + 2'h1;
      elapsed_q <= elapsed_d;
    end
  end

  // ==========================================================
  // slow transfer gates, one pointer per gate walking its toggle list
  for (genvar g = 0; g < NUM_GATES; g++)
  begin : gen_gate
    logic [5:0] ptr_q;
    logic done_q;
    logic [TOG_IDX_W-1:0] idx;
    logic [CNT_W-1:0] pos;
    logic fire;
    logic skip;

    assign idx = TOG_IDX_W'(GATE_BASE[g]) + TOG_IDX_W'(ptr_q);
    assign pos = toggle_position_q[idx];
    // zero only valid in first slot; ordered list means nothing follows it
    assign skip = (ptr_q != 6'h0) && (pos == '0);
    assign fire = !done_q && !skip && gate_cfg_q[GCFG_EN_LO+g] && (elapsed_q == pos);

    always_comb
    begin
      if (!out_en)
        gate_d[g] = 1'b0;
      else if (line_cycle_pulse_q)
        gate_d[g] = gate_cfg_q[g];
      else if (fire)
        gate_d[g] = !gate_q[g];
      else
        gate_d[g] = gate_q[g];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
      if (!presetn)
      begin
        ptr_q <= '0;
        done_q <= 1'b1;
      end
      else if (soft_rst_q)
      begin
        ptr_q <= '0;
        done_q <= 1'b1;
      end
      else if (line_cycle_pulse_q)
      begin
        ptr_q <= '0;
        done_q <= 1'b0;
      end
      else if (skip)
        done_q <= 1'b1;
      else if (fire)
      begin
        if (int'(ptr_q) == GATE_COUNT[g] - 1)
          done_q <= 1'b1;
        else
          ptr_q <= ptr_q + 6'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gate_q <= '0;
    else if (soft_rst_q)
      gate_q <= '0;
    else
      gate_q <= gate_d;
  end

  // clamp window from pixel counts after the fall; forced high while windowing is off
  assign win_d = !ctrl_q[CTRL_CLAMP_EN] ||
                 ((elapsed_d >= clamp_start_q) && (elapsed_d < clamp_end_q));

  // pin outputs; sync pin drives only in internal mode
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_q <= 1'b0;
      sync_out_q <= 1'b0;
      sync_oe_q <= 1'b0;
      pin_q <= 1'b0;
    end
    else
    begin
      win_q <= out_en && win_d;
      sync_oe_q <= internal_mode;
      unique case (ctrl_q[CTRL_OSEL_LO+:2])
        OSEL_LINE: sync_out_q <= out_en && internal_mode && line_cycle_pulse_d && !line_cycle_pulse_q;
        OSEL_CLAMP: sync_out_q <= out_en && internal_mode && win_d;
        default: sync_out_q <= 1'b0;
      endcase
      pin_q <= ctrl_q[CTRL_PIN_SEL] ? gate_d[0] : ctrl_q[CTRL_GPIO_VAL];
    end
  end

  // ==========================================================
  // fast clocks: one 48-slot pattern per master period
  // level per tap slot, repeated per sub-period
  function automatic logic [TAPS-1:0] tap_wave(input logic [EDGE_W-1:0] rise,
                                               input logic [EDGE_W-1:0] fall,
                                               input logic [1:0] per_sel);
    logic [TAPS-1:0] w;
    int j;
    w = '0;
    for (int i = 0; i < TAPS; i++)
    begin
      j = (per_sel == RATE_X4) ? (i % TAPS_X4) : (per_sel == RATE_X2) ? (i % TAPS_X2) : i;
      if (rise <= fall)
        w[i] = (j >= int'(rise)) && (j < int'(fall));
      else
        w[i] = (j >= int'(rise)) || (j < int'(fall));
    end
    return w;
  endfunction

  // taps are equal slices of the master period; the pad delay line locks to pclk
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < 8; i++)
        wave_q[i] <= '0;
    end
    else
    begin
      for (int c = 0; c < NUM_FAST; c++)
      begin
        logic [1:0] rate;
        logic [TAPS-1:0] w;
        rate = fast_cfg_q[c][FC_RATE_LO+:2];
        // only the two phase pairs may run x4
        if (rate == RATE_X4 && c >= 2)
          rate = RATE_X2;
        else if (rate != RATE_X4 && rate != RATE_X1)
          rate = RATE_X2;
        // separate x1 and x2 edge sets
        // an edge beyond the sub-period never occurs
        if (rate == RATE_X1)
          w = tap_wave(fast_cfg_q[c][FC_R1_LO+:EDGE_W], fast_cfg_q[c][FC_F1_LO+:EDGE_W], rate);
        else
          w = tap_wave(fast_cfg_q[c][FC_R2_LO+:EDGE_W], fast_cfg_q[c][FC_F2_LO+:EDGE_W], rate);
        if (!out_en)
          w = '0;
        // pairs share settings, second output inverted
        if (c < 2)
        begin
          wave_q[2*c] <= w;
          wave_q[2*c+1] <= out_en ? ~w : '0;
        end
        else
          wave_q[c+2] <= w;
      end
    end
  end

  // ==========================================================
  // outputs
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign line_sync_out = sync_out_q;
  assign line_sync_oe = sync_oe_q;
  assign slow_gate = gate_q;
  assign shared_general_pin_three = pin_q;
  assign dummy_clamp_window = win_q;
  assign phase_clock_one = wave_q[0];
  assign phase_clock_one_inverse = wave_q[1];
  assign phase_clock_three = wave_q[2];
  assign phase_clock_three_inverse = wave_q[3];
  assign last_stage_clock_one = wave_q[4];
  assign last_stage_clock_two = wave_q[5];
  assign reset_gate_clock = wave_q[6];
  assign clamp_gate_clock = wave_q[7];

endmodule
`default_nettype wire

// *** tb/stg_timing_gen_monitor.sv ***
// assertion checker for the sensor timing generator ports
`timescale 1ns/10ps
`default_nettype none
module stg_timing_gen_monitor
  import stg_pkg::*;
(
  // apb side
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // timing outputs
  input wire logic line_sync_out,
  input wire logic line_sync_oe,
  input wire logic [NUM_GATES-1:0] slow_gate,
  input wire logic [TAPS-1:0] phase_clock_one,
  input wire logic [TAPS-1:0] phase_clock_one_inverse,
  input wire logic [TAPS-1:0] phase_clock_three,
  input wire logic [TAPS-1:0] phase_clock_three_inverse
);
  // ==========================================
  // shadow configuration
  logic wr, cfg_wr, ok, lso_q, seen_q;
  logic [1:0] quiet_q;
  logic [9:0] ctrl_q;
  logic [CNT_W-1:0] len_q;
  logic [5:0] init_q;
  logic [20:0] gap_q;
  assign wr = psel && penable && pready && pwrite;
  assign cfg_wr = wr && paddr < OFS_STATUS;
  // internal mode, pin shows the line pulse, settings left alone for a while
  assign ok = ctrl_q[1:0] == 2'h3 && ctrl_q[5:3] == 3'h0 && quiet_q == 2'h3;
  // only completed writes count, as in the device
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ctrl_q <= 10'h000;
      len_q <= LINE_LEN_RST;
      init_q <= 6'h00;
    end
    else if (wr)
    begin
      if (paddr == OFS_CTRL) ctrl_q <= pwdata[9:0];
      if (paddr == OFS_LINE_LEN) len_q <= pwdata[CNT_W-1:0];
      if (paddr == OFS_GATE_CFG) init_q <= pwdata[5:0];
    end
  // line gap counter; any write below the status register restarts the measurement
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      lso_q <= 1'b0;
      seen_q <= 1'b0;
      gap_q <= 21'h0;
      quiet_q <= 2'h0;
    end
    else
    begin
      lso_q <= line_sync_out;
      gap_q <= (line_sync_out && !lso_q) ? 21'h1 : gap_q + 21'h1;
      seen_q <= !cfg_wr && (seen_q || (line_sync_out && !lso_q));
      quiet_q <= cfg_wr ? 2'h0 : quiet_q + {1'b0, quiet_q != 2'h3};
    end
  // ==========================================
  // properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_answer;
    !pready ##1 pready;
  endsequence
  property p_locked;
    !ctrl_q[0] && quiet_q == 2'h3 |-> slow_gate == '0 && phase_clock_one == '0 && phase_clock_three == '0;
  endproperty
  a_locked: assert property (p_locked) else $error("outputs move while locked");
  property p_period;
    ok && seen_q && line_sync_out && !lso_q |-> gap_q == len_q + 21'h1;
  endproperty
  a_period: assert property (p_period) else $error("line period wrong");
  property p_pulse_one;
    ok && line_sync_out && !lso_q |=> !line_sync_out;
  endproperty
  a_pulse_one: assert property (p_pulse_one) else $error("line pulse too long");
  property p_oe;
    cfg_wr && paddr == OFS_CTRL && pwdata[1] |-> ##[1:2] line_sync_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("sync pin not driven");
  property p_init;
    ok && lso_q && !line_sync_out |-> slow_gate == init_q;
  endproperty
  a_init: assert property (p_init) else $error("gates not at initial level");
  property p_inv_one;
    phase_clock_one != '0 |-> phase_clock_one_inverse == ~phase_clock_one;
  endproperty
  a_inv_one: assert property (p_inv_one) else $error("pair one not inverse");
  property p_inv_three;
    phase_clock_three != '0 |-> phase_clock_three_inverse == ~phase_clock_three;
  endproperty
  a_inv_three: assert property (p_inv_three) else $error("pair three not inverse");
  // apb answer after one wait
  property p_wait;
    psel && penable && !$past(penable) |-> s_answer;
  endproperty
  a_wait: assert property (p_wait) else $error("apb answer late");
  // error only with the answer
  property p_err;
    pslverr |-> pready;
  endproperty
  a_err: assert property (p_err) else $error("error without ready");
endmodule
`default_nettype wire

// *** tb/stg_sensor_model.sv ***
// line sync source standing in for the sensor board
`timescale 1ns/10ps
`default_nettype none
module stg_sensor_model
(
  // clock
  input wire logic pclk,
  // sync line towards the device
  output logic sync_level
);
  // idles inactive so no stray line starts
  initial sync_level = 1'b0;
  task automatic burst(input int n);
    sync_level <= 1'b1;
    repeat (n) @(posedge pclk);
    sync_level <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** tb/stg_timing_gen_tb.sv ***
// self-checking bench for the sensor timing generator
`timescale 1ns/10ps
`default_nettype none
module stg_timing_gen_tb
  import stg_pkg::*;
();
  // ==========================================
  // signals
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sens, pin, lso, loe, gpin, dcw;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [NUM_GATES-1:0] sg;
  logic [TAPS-1:0] fo [6];
  logic [7:0] seed;
  logic [64:0] exq [$];
  int err_total, n_checks;
  localparam logic [25:0] FCFG [9] = '{26'h0000600, 26'h000090C, 26'h1180000, 26'h2180000, 26'h2180000,
    26'h2180000, 26'h000090C, 26'h1180000, 26'h3180000};
  localparam logic [TAPS-1:0] FEXP [9] = '{48'h000000FFFFFF, 48'h000FFFFFF000, 48'h00003F00003F,
    48'h03F03F03F03F, 48'h03F03F03F03F, 48'h00003F00003F, 48'h000FFFFFF000, 48'h00003F00003F,
    48'h00003F00003F};
  localparam int FCH [9] = '{0, 0, 0, 0, 1, 2, 3, 4, 5};
  // pin level: device drives it in internal mode
  assign pin = loe ? lso : sens;
  // clock
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  stg_timing_gen i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_line_sync_input(pin), .line_sync_out(lso), .line_sync_oe(loe), .slow_gate(sg),
    .shared_general_pin_three(gpin), .dummy_clamp_window(dcw), .phase_clock_one(fo[0]),
    .phase_clock_one_inverse(), .phase_clock_three(fo[1]), .phase_clock_three_inverse(),
    .last_stage_clock_one(fo[2]), .last_stage_clock_two(fo[3]), .reset_gate_clock(fo[4]),
    .clamp_gate_clock(fo[5]));
  stg_sensor_model i_sensor (.pclk(pclk), .sync_level(sens));
  // ==========================================
  // reporting and compares
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic miss(input string s);
    err_total++;
    $display("mismatch at %0t: %s", $time, s);
  endtask
  task automatic chk_lv(input logic [TAPS-1:0] got, input logic [TAPS-1:0] exp);
    n_checks++;
    if (got !== exp) miss($sformatf("level %h expected %h", got, exp));
  endtask
  task automatic chk_rd(input logic [31:0] got, input logic err, input logic [64:0] e);
    n_checks++;
    if ((got & e[63:32]) !== e[31:0] || err !== e[64]) miss($sformatf("read %h err %b", got, err));
  endtask
  // apb transfer; reads note their expectation first
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    input logic [31:0] m = 32'hFFFFFFFF, input logic e = 1'b0);
    int n;
    if (!w) exq.push_back({e, m, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && pready !== 1'b1; n++) @(posedge pclk);
    if (pready !== 1'b1) miss("no apb answer");
    if (pready !== 1'b1) conclude();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // read results are matched oldest first
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite)
    begin
      if (exq.size() == 0) miss("unexpected read");
      else chk_rd(prdata, pslverr, exq.pop_front());
    end
  // ==========================================
  // main sequence
  initial
  begin
    int n, i, k;
    logic [CNT_W-1:0] len;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    err_total = 0;
    n_checks = 0;
    seed = 8'h29;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, OFS_CTRL, 32'h0);
    apb(1'b0, OFS_LINE_LEN, 32'h00FFF);
    apb(1'b0, OFS_FAST_BASE, 32'h600);
    apb(1'b0, 12'h0FC, 32'h0, 32'hFFFFFFFF, 1'b1);
    chk_lv(fo[0], '0);
    // external line: a zero first position fires right after the line
    apb(1'b1, OFS_TOG_BASE, 32'h0);
    apb(1'b1, OFS_TOG_BASE + 12'h004, 32'h0);
    apb(1'b1, OFS_GATE_CFG, 32'h100);
    apb(1'b1, OFS_LINE_LEN, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h1);
    i_sensor.burst(2);
    repeat (15) @(posedge pclk);
    chk_lv(48'(sg[0]), 48'h0);
    i_sensor.burst(4);
    for (n = 0; n < 15 && sg[0] !== 1'b1; n++) @(posedge pclk);
    chk_lv(48'(sg[0]), 48'h1);
    // active-low polarity: the idle low pin reads as active
    apb(1'b1, OFS_CTRL, 32'h4);
    apb(1'b0, OFS_STATUS, 32'h200000, 32'h200000);
    // counter held after soft reset
    apb(1'b1, OFS_CTRL, 32'h200);
    apb(1'b1, OFS_CTRL, 32'h23);
    repeat (8) @(posedge pclk);
    apb(1'b0, OFS_STATUS, 32'h100000, 32'h1FFFFF);
    // internal lines with random length, start gate toggling once at 1
    for (k = 0; k < 2; k++)
    begin
      seed = lfsr(seed);
      len = CNT_W'(4 + seed[2:0]);
      apb(1'b1, OFS_CTRL, 32'h200);
      apb(1'b1, OFS_LINE_LEN, 32'(len));
      // rising positions, zero ends the list
      apb(1'b1, OFS_TOG_BASE, 32'h1);
      apb(1'b1, OFS_GATE_CFG, 32'h102);
      apb(1'b1, OFS_CTRL, 32'h83);
      for (n = 0; n < 40 && lso !== 1'b1; n++) @(posedge pclk);
      for (n = 1; n <= len + 1; n++)
      begin
        @(posedge pclk);
        if (n == 2) chk_lv(48'(sg[0]), 48'h0);
        if (n == 3) chk_lv(48'(sg[0]), 48'h1);
        if (n == len) chk_lv(48'(sg[1:0]), 48'h3);
        if (n == len) chk_lv(48'(gpin), 48'h1);
        chk_lv(48'(lso), 48'(n == len + 1));
      end
    end
    // clamp window on the pin, window forced open, general pin value set
    apb(1'b1, OFS_CTRL, 32'h10B);
    repeat (3) @(posedge pclk);
    chk_lv(48'({loe, lso, gpin, dcw}), 48'hF);
    // programmed window: two clocks per ten-clock line on both outputs
    apb(1'b1, OFS_CLAMP_START, 32'h2);
    apb(1'b1, OFS_CLAMP_END, 32'h4);
    apb(1'b1, OFS_CTRL, 32'h4B);
    n = 0;
    repeat (20)
    begin
      @(posedge pclk);
      n += dcw + lso;
    end
    chk_lv(48'(n), 48'h8);
    // fast clock rates and edges, all six non-inverted fast outputs
    for (i = 0; i < 9; i++)
    begin
      apb(1'b1, OFS_FAST_BASE + 12'(4 * FCH[i]), 32'(FCFG[i]));
      repeat (2) @(posedge pclk);
      chk_lv(fo[FCH[i]], FEXP[i]);
    end
    conclude();
  end
endmodule
bind stg_timing_gen stg_timing_gen_monitor i_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .line_sync_out(line_sync_out), .line_sync_oe(line_sync_oe), .slow_gate(slow_gate),
  .phase_clock_one(phase_clock_one), .phase_clock_one_inverse(phase_clock_one_inverse),
  .phase_clock_three(phase_clock_three), .phase_clock_three_inverse(phase_clock_three_inverse));
`default_nettype wire
